// >>> ebsc_ctrl.sv
// external bus controller for sram-type and burst-rom areas: wait insertion,
// output-disable gaps, alignment checks and splitting onto a 16-bit bus.
// assumes the cpu drops each request right after the edge that takes it and decodes the area,
// device width and burst-rom selection itself; all pins on core_clk.
//
// Our own choice: strobed register access.
`timescale 1ns/100ps
module ebsc_ctrl
   import ebsc_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic hot_start,
   input wire logic [19:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [1:0] req_size,
   input wire logic [23:0] req_addr,
   input wire logic [31:0] req_wdata,
   input wire logic [4:0] req_area,
   input wire logic req_dev8,
   input wire logic req_burst_rom,
   input wire logic req_burst,
   input wire logic req_force_align,
   output logic busy,
   output logic done,
   output logic addr_err,
   output logic [31:0] rdata,
   output logic beat_valid,
   output logic [15:0] beat_data,
   output logic [23:0] ext_addr,
   output logic [15:0] ext_dout,
   output logic ext_doe,
   input wire logic [15:0] ext_din,
   input wire logic ext_wait_n,
   output logic read_strobe_n,
   output logic write_strobe_high_n,
   output logic write_strobe_low_n,
   output logic byte_sel_low_n,
   output logic byte_sel_high_n,
   output logic [4:0] bus_area
);
   logic [15:0] cfg_reg [EBSC_NUM_REGS];
   logic [15:0] cfg_next [EBSC_NUM_REGS];
   logic [15:0] rdata_reg, rdata_next;
   logic wsync1_reg, wsync2_reg, wsync3_reg, wfilt_reg, wfilt_next;
   ebsc_state_t state_reg, state_next;
   logic [3:0] cnt_reg, cnt_next, len_reg, len_next, ops_reg, ops_next;
   logic [2:0] op_reg, op_next;
   logic wr_reg, wr_next, dev8_reg, dev8_next, brst_reg, brst_next, brom_reg, brom_next;
   logic [1:0] size_reg, size_next;
   logic [23:0] base_reg, base_next;
   logic [31:0] wd_reg, wd_next, rbuf_reg, rbuf_next;
   logic [4:0] area_reg, area_next;
   logic last_rd_reg, last_rd_next;
   logic [4:0] last_area_reg, last_area_next;
   logic [1:0] last_dly_reg, last_dly_next;
   logic busy_reg, busy_next, done_reg, done_next, err_reg, err_next;
   logic bv_reg, bv_next;
   logic [15:0] bd_reg, bd_next;
   logic [23:0] xa_reg, xa_next;
   logic [15:0] xd_reg, xd_next;
   logic xoe_reg, xoe_next, rdn_reg, rdn_next, wrh_reg, wrh_next, wrl_reg, wrl_next;
   logic bsl_reg, bsl_next, bsh_reg, bsh_next;
   logic [4:0] barea_reg, barea_next;

   // wait count and disable delay of the pair owning an area
   function automatic logic [4:0] pair_cfg(input logic [4:0] area,
                                           input logic [15:0] p11,
                                           input logic [15:0] p9,
                                           input logic [15:0] p7,
                                           input logic [15:0] p64);
      logic [4:0] r;
      r = {p11[EBSC_DLY_LSB +: 2], p11[EBSC_WAIT_LSB +: 3]};
      case (area)
         5'h09, 5'h0A: r = {p9[EBSC_DLY_LSB +: 2], p9[EBSC_WAIT_LSB +: 3]};
         5'h07, 5'h08: r = {p7[EBSC_DLY_LSB +: 2], p7[EBSC_WAIT_LSB +: 3]};
         5'h06: r = {p64[EBSC_A6_DLY_LSB +: 2], p64[EBSC_A6_WAIT_LSB +: 3]};
         5'h04, 5'h05: r = {p64[EBSC_DLY_LSB +: 2], p64[EBSC_WAIT_LSB +: 3]};
         default: r = {p11[EBSC_DLY_LSB +: 2], p11[EBSC_WAIT_LSB +: 3]};
      endcase
      return r;
   endfunction : pair_cfg

   // configuration registers and register port
   always_comb
   begin
      for (int i = 0; i < EBSC_NUM_REGS; i++)
      begin
         cfg_next[i] = cfg_reg[i];
      end
      rdata_next = 16'h0000;
      if (reg_wr)
      begin
         unique case (reg_addr)
            EBSC_OFS_PAIR11: cfg_next[EBSC_IDX_PAIR11] = reg_wdata & EBSC_MASK_PAIR;
            EBSC_OFS_PAIR9: cfg_next[EBSC_IDX_PAIR9] = reg_wdata & EBSC_MASK_PAIR9;
            EBSC_OFS_PAIR7: cfg_next[EBSC_IDX_PAIR7] = reg_wdata & EBSC_MASK_PAIR;
            EBSC_OFS_AREA64: cfg_next[EBSC_IDX_AREA64] = reg_wdata & EBSC_MASK_AREA64;
            EBSC_OFS_BUSCTL: cfg_next[EBSC_IDX_BUSCTL] = reg_wdata & EBSC_MASK_BUSCTL;
            default: ;
         endcase
      end
      if (reg_rd)
      begin
         unique case (reg_addr)
            EBSC_OFS_PAIR11: rdata_next = cfg_reg[EBSC_IDX_PAIR11];
            EBSC_OFS_PAIR9: rdata_next = cfg_reg[EBSC_IDX_PAIR9];
            EBSC_OFS_PAIR7: rdata_next = cfg_reg[EBSC_IDX_PAIR7];
            EBSC_OFS_AREA64: rdata_next = cfg_reg[EBSC_IDX_AREA64];
            EBSC_OFS_BUSCTL: rdata_next = cfg_reg[EBSC_IDX_BUSCTL];
            default: rdata_next = 16'h0000; // unmapped reads as zero
         endcase
      end
   end

   // cold start reloads defaults, hot start leaves the settings alone
   always_ff @(posedge core_clk)
   begin
      if (sys_rst && !hot_start)
      begin
         cfg_reg[EBSC_IDX_PAIR11] <= EBSC_RST_PAIR;
         cfg_reg[EBSC_IDX_PAIR9] <= EBSC_RST_PAIR;
         cfg_reg[EBSC_IDX_PAIR7] <= EBSC_RST_PAIR;
         cfg_reg[EBSC_IDX_AREA64] <= EBSC_RST_AREA64;
         cfg_reg[EBSC_IDX_BUSCTL] <= EBSC_RST_BUSCTL;
      end
      else if (!sys_rst)
      begin
         cfg_reg <= cfg_next;
      end
      rdata_reg <= sys_rst ? 16'h0000 : rdata_next;
   end

   // external wait pin: three flops, a change counts when the last two agree
   always_comb
   begin
      wfilt_next = (wsync2_reg == wsync3_reg) ? wsync3_reg : wfilt_reg;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         wsync1_reg <= 1'b1;
         wsync2_reg <= 1'b1;
         wsync3_reg <= 1'b1;
         wfilt_reg <= 1'b1;
      end
      else
      begin
         wsync1_reg <= ext_wait_n;
         wsync2_reg <= wsync1_reg;
         wsync3_reg <= wsync2_reg;
         wfilt_reg <= wfilt_next;
      end
   end

   // sequencer: gap, per-operation timing, lane steering and data capture
   always_comb
   begin
      logic [4:0] pc;
      logic [2:0] wt;
      logic [3:0] wlen;
      logic mis, gap, start, finish, hold, ends;
      logic [23:0] a;
      pc = pair_cfg(area_reg, cfg_reg[EBSC_IDX_PAIR11], cfg_reg[EBSC_IDX_PAIR9],
                    cfg_reg[EBSC_IDX_PAIR7], cfg_reg[EBSC_IDX_AREA64]);
      wt = 3'h0;
      wlen = 4'h0;
      mis = 1'b0;
      gap = 1'b0;
      start = 1'b0;
      finish = 1'b0;
      hold = 1'b0;
      ends = 1'b0;
      a = req_addr;
      state_next = state_reg;
      cnt_next = cnt_reg;
      len_next = len_reg;
      ops_next = ops_reg;
      op_next = op_reg;
      wr_next = wr_reg;
      dev8_next = dev8_reg;
      brst_next = brst_reg;
      brom_next = brom_reg;
      size_next = size_reg;
      base_next = base_reg;
      wd_next = wd_reg;
      rbuf_next = rbuf_reg;
      area_next = area_reg;
      last_rd_next = last_rd_reg;
      last_area_next = last_area_reg;
      last_dly_next = last_dly_reg;
      busy_next = busy_reg;
      done_next = 1'b0;
      err_next = 1'b0;
      bv_next = 1'b0;
      bd_next = bd_reg;
      xa_next = xa_reg;
      xd_next = xd_reg;
      xoe_next = xoe_reg;
      rdn_next = rdn_reg;
      wrh_next = wrh_reg;
      wrl_next = wrl_reg;
      bsl_next = bsl_reg;
      bsh_next = bsh_reg;
      barea_next = barea_reg;
      unique case (state_reg)
         EBSC_ST_IDLE:
         begin
            if (req_valid)
            begin
               mis = ((req_size == EBSC_SZ_HALF) && req_addr[0]) ||
                     ((req_size == EBSC_SZ_WORD) && (req_addr[1:0] != 2'h0));
               if (req_size == EBSC_SZ_HALF)
               begin
                  a[0] = 1'b0;
               end
               else if (req_size == EBSC_SZ_WORD)
               begin
                  a[1:0] = 2'h0;
               end
               if (mis && !req_force_align)
               begin
                  err_next = 1'b1;
                  done_next = 1'b1;
               end
               else
               begin
                  busy_next = 1'b1;
                  base_next = a;
                  wr_next = req_write;
                  size_next = req_size;
                  wd_next = req_wdata;
                  area_next = req_area;
                  dev8_next = req_dev8;
                  brom_next = req_burst_rom &&
                              ((req_area == 5'h09) || (req_area == 5'h0A));
                  brst_next = req_burst && !req_write && brom_next;
                  rbuf_next = 32'h0000_0000;
                  op_next = 3'h0;
                  if (brst_next)
                  begin
                     ops_next = cfg_reg[EBSC_IDX_BUSCTL][EBSC_BLEN8_BIT] ?
                                EBSC_BURST_LONG : EBSC_BURST_SHORT;
                  end
                  else if (req_area == EBSC_AREA_INTERNAL)
                  begin
                     ops_next = 4'h0;
                  end
                  else if (req_size == EBSC_SZ_WORD)
                  begin
                     ops_next = req_dev8 ? 4'h4 : 4'h2;
                  end
                  else if (req_size == EBSC_SZ_HALF)
                  begin
                     ops_next = req_dev8 ? 4'h2 : 4'h1;
                  end
                  else
                  begin
                     ops_next = 4'h1;
                  end
                  // gap only after an external read, for writes or another area
                  gap = last_rd_reg && (req_write || (req_area != last_area_reg));
                  if (gap)
                  begin
                     state_next = EBSC_ST_GAP;
                     cnt_next = {2'h0, last_dly_reg};
                  end
                  else if (ops_next == 4'h0)
                  begin
                     finish = 1'b1;
                  end
                  else
                  begin
                     start = 1'b1;
                  end
               end
            end
         end
         EBSC_ST_GAP:
         begin
            // delay code d stands for d+0.5 cycles, rounded up to d+1
            if (cnt_reg == 4'h0)
            begin
               last_rd_next = 1'b0;
               if (ops_reg == 4'h0)
               begin
                  finish = 1'b1;
               end
               else
               begin
                  start = 1'b1;
               end
            end
            else
            begin
               cnt_next = cnt_reg - 4'h1;
            end
         end
         EBSC_ST_OP:
         begin
            // burst-rom reads take no external wait; writes to them do
            hold = cfg_reg[EBSC_IDX_BUSCTL][EBSC_WAIT_EN_BIT] && !wfilt_reg &&
                   !(brom_reg && !wr_reg);
            // one bit wider so a saturated count still closes the operation
            ends = (({1'b0, cnt_reg} + 5'h01) >= {1'b0, len_reg}) && !hold;
            cnt_next = (cnt_reg == 4'hF) ? cnt_reg : cnt_reg + 4'h1;
            if (ends)
            begin
               if (!wr_reg)
               begin
                  if (dev8_reg)
                  begin
                     rbuf_next[{op_reg[1:0], 3'h0} +: 8] = ext_din[7:0];
                  end
                  else if (size_reg == EBSC_SZ_BYTE)
                  begin
                     rbuf_next[7:0] = base_reg[0] ? ext_din[15:8] : ext_din[7:0];
                  end
                  else
                  begin
                     rbuf_next[{op_reg[0], 4'h0} +: 16] = ext_din;
                  end
                  bv_next = brst_reg;
                  bd_next = ext_din;
               end
               if ({1'b0, op_reg} + 4'h1 < ops_reg)
               begin
                  op_next = op_reg + 3'h1;
                  start = 1'b1;
               end
               else
               begin
                  finish = 1'b1;
                  last_rd_next = !wr_reg && (pc[4:3] != 2'h0) ||
                                 (!wr_reg && 1'b1);
                  last_area_next = area_reg;
                  last_dly_next = pc[4:3];
               end
            end
         end
      endcase
      // launch one bus operation: address, lanes, strobes and length
      if (start)
      begin
         pc = pair_cfg(area_next, cfg_reg[EBSC_IDX_PAIR11], cfg_reg[EBSC_IDX_PAIR9],
                       cfg_reg[EBSC_IDX_PAIR7], cfg_reg[EBSC_IDX_AREA64]);
         wt = (brst_next && (op_next != 3'h0)) ?
              {1'b0, cfg_reg[EBSC_IDX_PAIR9][EBSC_BWAIT_LSB +: 2]} : pc[2:0];
         wlen = {1'b0, wt} + 4'h1;
         if (wr_next && (wlen < EBSC_WR_MIN_CYC))
         begin
            wlen = EBSC_WR_MIN_CYC;
         end
         len_next = wlen;
         cnt_next = 4'h0;
         state_next = EBSC_ST_OP;
         barea_next = area_next;
         xa_next = base_next + (dev8_next ? {21'h0, op_next} : {20'h0, op_next, 1'b0});
         xoe_next = wr_next;
         rdn_next = wr_next;
         if (dev8_next)
         begin
            xd_next = {8'h00, wd_next[{op_next[1:0], 3'h0} +: 8]};
            wrl_next = !wr_next;
            wrh_next = 1'b1;
            bsl_next = 1'b0;
            bsh_next = 1'b1;
         end
         else if (size_next == EBSC_SZ_BYTE)
         begin
            xd_next = {wd_next[7:0], wd_next[7:0]};
            wrl_next = !(wr_next && !base_next[0]);
            wrh_next = !(wr_next && base_next[0]);
            bsl_next = base_next[0];
            bsh_next = !base_next[0];
         end
         else
         begin
            xd_next = wd_next[{op_next[0], 4'h0} +: 16];
            wrl_next = !wr_next;
            wrh_next = !wr_next;
            bsl_next = 1'b0;
            bsh_next = 1'b0;
         end
      end
      // close the access and release the pins
      if (finish)
      begin
         state_next = EBSC_ST_IDLE;
         busy_next = 1'b0;
         done_next = 1'b1;
         xoe_next = 1'b0;
         rdn_next = 1'b1;
         wrh_next = 1'b1;
         wrl_next = 1'b1;
         bsl_next = 1'b1;
         bsh_next = 1'b1;
         if (area_next == EBSC_AREA_INTERNAL)
         begin
            last_rd_next = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         state_reg <= EBSC_ST_IDLE;
         cnt_reg <= 4'h0;
         len_reg <= 4'h0;
         ops_reg <= 4'h0;
         op_reg <= 3'h0;
         wr_reg <= 1'b0;
         dev8_reg <= 1'b0;
         brst_reg <= 1'b0;
         brom_reg <= 1'b0;
         size_reg <= 2'h0;
         base_reg <= 24'h000000;
         wd_reg <= 32'h0000_0000;
         rbuf_reg <= 32'h0000_0000;
         area_reg <= 5'h00;
         last_rd_reg <= 1'b0;
         last_area_reg <= 5'h00;
         last_dly_reg <= 2'h0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         err_reg <= 1'b0;
         bv_reg <= 1'b0;
         bd_reg <= 16'h0000;
         xa_reg <= 24'h000000;
         xd_reg <= 16'h0000;
         xoe_reg <= 1'b0;
         rdn_reg <= 1'b1;
         wrh_reg <= 1'b1;
         wrl_reg <= 1'b1;
         bsl_reg <= 1'b1;
         bsh_reg <= 1'b1;
         barea_reg <= 5'h00;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         len_reg <= len_next;
         ops_reg <= ops_next;
         op_reg <= op_next;
         wr_reg <= wr_next;
         dev8_reg <= dev8_next;
         brst_reg <= brst_next;
         brom_reg <= brom_next;
         size_reg <= size_next;
         base_reg <= base_next;
         wd_reg <= wd_next;
         rbuf_reg <= rbuf_next;
         area_reg <= area_next;
         last_rd_reg <= last_rd_next;
         last_area_reg <= last_area_next;
         last_dly_reg <= last_dly_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
         err_reg <= err_next;
         bv_reg <= bv_next;
         bd_reg <= bd_next;
         xa_reg <= xa_next;
         xd_reg <= xd_next;
         xoe_reg <= xoe_next;
         rdn_reg <= rdn_next;
         wrh_reg <= wrh_next;
         wrl_reg <= wrl_next;
         bsl_reg <= bsl_next;
         bsh_reg <= bsh_next;
         barea_reg <= barea_next;
      end
   end

   // every output straight from its flip-flop
   assign reg_rdata = rdata_reg;
   assign busy = busy_reg;
   assign done = done_reg;
   assign addr_err = err_reg;
   assign rdata = rbuf_reg;
   assign beat_valid = bv_reg;
   assign beat_data = bd_reg;
   assign ext_addr = xa_reg;
   assign ext_dout = xd_reg;
   assign ext_doe = xoe_reg;
   assign read_strobe_n = rdn_reg;
   assign write_strobe_high_n = wrh_reg;
   assign write_strobe_low_n = wrl_reg;
   assign byte_sel_low_n = bsl_reg;
   assign byte_sel_high_n = bsh_reg;
   assign bus_area = barea_reg;
endmodule : ebsc_ctrl

// >>> ebsc_pkg.sv
// constants for the external bus controller: register map, field layout,
// cold-start values, access encodings and controller states.
// assumes one bus clock and a plain register port with printed offsets.
package ebsc_pkg;
   // register offsets as seen on the register port
   localparam logic [19:0] EBSC_OFS_PAIR11 = 20'h48124;
   localparam logic [19:0] EBSC_OFS_PAIR9 = 20'h48126;
   localparam logic [19:0] EBSC_OFS_PAIR7 = 20'h48128;
   localparam logic [19:0] EBSC_OFS_AREA64 = 20'h4812A;
   localparam logic [19:0] EBSC_OFS_BUSCTL = 20'h4812E;
   // register indices inside the configuration array
   localparam int EBSC_IDX_PAIR11 = 0;
   localparam int EBSC_IDX_PAIR9 = 1;
   localparam int EBSC_IDX_PAIR7 = 2;
   localparam int EBSC_IDX_AREA64 = 3;
   localparam int EBSC_IDX_BUSCTL = 4;
   localparam int EBSC_NUM_REGS = 5;
   // field positions
   localparam int EBSC_WAIT_LSB = 0;
   localparam int EBSC_DLY_LSB = 4;
   localparam int EBSC_A6_WAIT_LSB = 8;
   localparam int EBSC_A6_DLY_LSB = 12;
   localparam int EBSC_BWAIT_LSB = 9;
   localparam int EBSC_WAIT_EN_BIT = 0;
   localparam int EBSC_BLEN8_BIT = 13;
   // cold-start values: seven waits, longest disable delay, burst wait zero
   localparam logic [15:0] EBSC_RST_PAIR = 16'h0037;
   localparam logic [15:0] EBSC_RST_AREA64 = 16'h3737;
   localparam logic [15:0] EBSC_RST_BUSCTL = 16'h0000;
   // write masks of implemented bits
   localparam logic [15:0] EBSC_MASK_PAIR = 16'h0037;
   localparam logic [15:0] EBSC_MASK_PAIR9 = 16'h0637;
   localparam logic [15:0] EBSC_MASK_AREA64 = 16'h3737;
   localparam logic [15:0] EBSC_MASK_BUSCTL = 16'h2001;
   // access sizes
   localparam logic [1:0] EBSC_SZ_BYTE = 2'h0;
   localparam logic [1:0] EBSC_SZ_HALF = 2'h1;
   localparam logic [1:0] EBSC_SZ_WORD = 2'h2;
   // area code of internal devices
   localparam logic [4:0] EBSC_AREA_INTERNAL = 5'h00;
   // minimum write cycle length and burst lengths
   localparam logic [3:0] EBSC_WR_MIN_CYC = 4'h2;
   localparam logic [3:0] EBSC_BURST_SHORT = 4'h4;
   localparam logic [3:0] EBSC_BURST_LONG = 4'h8;
   typedef enum logic [1:0] {EBSC_ST_IDLE, EBSC_ST_GAP, EBSC_ST_OP} ebsc_state_t;
endpackage : ebsc_pkg

// >>> ebsc_ctrl_chk.sv
// port checker for the external bus controller
// assumes one core_clk domain with synchronous active-high sys_rst
`timescale 1ns/100ps
module ebsc_ctrl_chk
   import ebsc_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [19:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic req_valid,
   input wire logic [1:0] req_size,
   input wire logic [23:0] req_addr,
   input wire logic [4:0] req_area,
   input wire logic req_force_align,
   input wire logic busy,
   input wire logic done,
   input wire logic addr_err,
   input wire logic read_strobe_n,
   input wire logic write_strobe_low_n,
   input wire logic write_strobe_high_n
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // request taken while idle, internal area left out since it has no pins
   logic take;
   assign take = req_valid && !busy && !done && req_area != EBSC_AREA_INTERNAL;
   chk_err_done: assert property (addr_err |-> done && !busy)
      else $error("address error without done");
   chk_misalign_err: assert property (take && req_size == EBSC_SZ_HALF && req_addr[0]
      && !req_force_align |=> done && addr_err)
      else $error("misaligned half-word not refused");
   chk_byte_runs: assert property (take && req_size == EBSC_SZ_BYTE |=> busy && !addr_err)
      else $error("byte access refused");
   chk_busy_end: assert property ($fell(busy) |-> done)
      else $error("busy fell without done");
   chk_wrl_two: assert property ($fell(write_strobe_low_n) |=> !write_strobe_low_n)
      else $error("low write strobe shorter than two cycles");
   chk_wrh_two: assert property ($fell(write_strobe_high_n) |=> !write_strobe_high_n)
      else $error("high write strobe shorter than two cycles");
   chk_rd_wr_apart: assert property (!read_strobe_n |-> write_strobe_low_n && write_strobe_high_n)
      else $error("read and write strobes together");
   chk_ctl_mask: assert property (reg_rd && reg_addr == EBSC_OFS_BUSCTL
      |=> (reg_rdata & ~EBSC_MASK_BUSCTL) == 16'h0000)
      else $error("unimplemented control bits read nonzero");
   cov_err: cover property (addr_err);
   cov_read: cover property ($fell(read_strobe_n));
   cov_write: cover property ($fell(write_strobe_high_n));
endmodule : ebsc_ctrl_chk
bind ebsc_ctrl ebsc_ctrl_chk u_chk (.core_clk, .sys_rst, .reg_addr, .reg_rd, .reg_rdata,
   .req_valid, .req_size, .req_addr, .req_area, .req_force_align, .busy, .done, .addr_err,
   .read_strobe_n, .write_strobe_low_n, .write_strobe_high_n);

// >>> ebsc_mem_model.sv
// external memory partner: byte store behind the 16-bit data bus
// assumes strobes are sampled on core_clk rising edges
`timescale 1ns/100ps
module ebsc_mem_model (
   input wire logic core_clk,
   input wire logic dev8,
   input wire logic slow,
   input wire logic [23:0] ext_addr,
   input wire logic [15:0] ext_dout,
   input wire logic read_strobe_n,
   input wire logic write_strobe_low_n,
   input wire logic write_strobe_high_n,
   output logic [15:0] ext_din,
   output logic ext_wait_n
);
   logic [7:0] mem [0:4095];
   logic [11:0] a;
   logic [3:0] cnt = 4'h0;
   logic [15:0] last = 16'h0000;
   assign a = ext_addr[11:0];
   // released bus shows the inverse of the last value, no pull-up here
   assign ext_din = read_strobe_n ? ~last : dev8 ? {~last[15:8], mem[a]}
      : {mem[a | 12'h001], mem[a & 12'hFFE]};
   // slow part holds wait low until six strobe cycles have passed
   assign ext_wait_n = !slow || cnt >= 4'h6;
   // strobe-cycle counter and write lanes
   always @(posedge core_clk)
   begin
      cnt <= (read_strobe_n && write_strobe_low_n && write_strobe_high_n) ? 4'h0
         : cnt + {3'h0, cnt != 4'hF};
      if (!read_strobe_n) last <= ext_din;
      if (!write_strobe_low_n) mem[dev8 ? a : a & 12'hFFE] <= ext_dout[7:0];
      if (!write_strobe_high_n) mem[a | 12'h001] <= ext_dout[15:8];
   end
endmodule : ebsc_mem_model

// >>> tb_ebsc_ctrl.sv
// self-checking bench for the external bus controller
// assumes the memory partner model and the bound port checker
`timescale 1ns/100ps
module tb_ebsc_ctrl;
   import ebsc_pkg::*;
   logic core_clk = 1'b0, sys_rst = 1'b1, hot_start = 1'b0, slow = 1'b0;
   logic [19:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, beat_data, ext_dout, ext_din;
   logic reg_wr, reg_rd, req_valid, req_write, req_dev8, req_burst_rom, req_burst;
   logic req_force_align, busy, done, addr_err, beat_valid, ext_doe, ext_wait_n;
   logic [1:0] req_size;
   logic [23:0] req_addr, ext_addr;
   logic [31:0] req_wdata, rdata;
   logic [4:0] req_area, bus_area;
   logic read_strobe_n, write_strobe_high_n, write_strobe_low_n, byte_sel_low_n, byte_sel_high_n;
   int fail_count = 0, cmp_count = 0, len, beats;
   always #50 core_clk = ~core_clk;
   ebsc_ctrl u_dut (.core_clk, .sys_rst, .hot_start, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .req_valid, .req_write, .req_size, .req_addr, .req_wdata, .req_area,
      .req_dev8, .req_burst_rom, .req_burst, .req_force_align, .busy, .done, .addr_err,
      .rdata, .beat_valid, .beat_data, .ext_addr, .ext_dout, .ext_doe, .ext_din,
      .ext_wait_n, .read_strobe_n, .write_strobe_high_n, .write_strobe_low_n,
      .byte_sel_low_n, .byte_sel_high_n, .bus_area);
   ebsc_mem_model u_mem (.core_clk, .dev8(req_dev8), .slow, .ext_addr, .ext_dout,
      .read_strobe_n, .write_strobe_low_n, .write_strobe_high_n, .ext_din, .ext_wait_n);
   task automatic print_verdict;
      if (fail_count == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : print_verdict
   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp32
   task automatic rst(input logic h);
      @(posedge core_clk);
      {hot_start, sys_rst} <= {h, 1'b1};
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'b0;
   endtask : rst
   task automatic wr(input logic [19:0] a, input logic [15:0] d);
      @(posedge core_clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [19:0] a, input logic [15:0] exp);
      @(posedge core_clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 cmp32({16'h0000, reg_rdata}, {16'h0000, exp});
   endtask : rd
   // flags: dev8, burst rom, burst, force align, error expected; el 0 skips length
   task automatic acc(input logic w, input logic [1:0] sz, input logic [23:0] a,
      input logic [31:0] d, input logic [4:0] ar, input logic [4:0] fl, input int el);
      @(posedge core_clk);
      {req_valid, req_write, req_size, req_addr, req_wdata, req_area} <= {1'b1, w, sz, a, d, ar};
      {req_dev8, req_burst_rom, req_burst, req_force_align} <= fl[4:1];
      len = 0;
      beats = 0;
      // count from the taking edge; a refused access ends at that edge
      do
      begin
         @(posedge core_clk);
         req_valid <= 1'b0;
         #1 len++;
         beats += int'(beat_valid === 1'b1);
      end
      while (done !== 1'b1 && len < 200);
      cmp32({31'h0, done}, 32'h1);
      if (el != 0) cmp32(len, el);
      cmp32({31'h0, addr_err}, {31'h0, fl[0]});
      if (!w && !fl[2] && !fl[0]) cmp32(rdata, d);
   endtask : acc
   // watchdog, far beyond the hundred and sixty or so cycles the sequence needs
   initial
   begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      print_verdict();
   end
   initial
   begin
      {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
      {req_valid, req_write, req_size, req_addr, req_wdata, req_area} = '0;
      {req_dev8, req_burst_rom, req_burst, req_force_align} = '0;
      rst(1'b0);
      rd(EBSC_OFS_PAIR11, EBSC_RST_PAIR);
      rd(EBSC_OFS_PAIR9, EBSC_RST_PAIR);
      rd(EBSC_OFS_AREA64, EBSC_RST_AREA64);
      rd(EBSC_OFS_BUSCTL, 16'h0000);
      rd(20'h48130, 16'h0000);
      wr(EBSC_OFS_AREA64, 16'hFFFF);
      rd(EBSC_OFS_AREA64, 16'h3737);
      wr(EBSC_OFS_PAIR7, 16'h0000);
      wr(EBSC_OFS_PAIR11, 16'h0030);
      wr(EBSC_OFS_PAIR9, 16'h0202);
      acc(1, EBSC_SZ_WORD, 'h100, 32'h11223344, 7, 0, 5);
      acc(0, EBSC_SZ_WORD, 'h100, 32'h11223344, 7, 0, 3);
      acc(0, EBSC_SZ_HALF, 'h102, 32'h1122, 7, 0, 2);
      acc(1, EBSC_SZ_BYTE, 'h101, 32'hAB, 7, 0, 4);
      acc(0, EBSC_SZ_BYTE, 'h101, 32'hAB, 8, 0, 2);
      acc(0, EBSC_SZ_HALF, 'h100, 32'hAB44, 7, 0, 3);
      acc(0, EBSC_SZ_WORD, 'h100, 32'h1122AB44, 11, 5'h10, 6);
      acc(0, EBSC_SZ_HALF, 'h100, 32'hAB44, 7, 0, 6);
      acc(0, EBSC_SZ_HALF, 'h101, 0, 7, 5'h01, 1);
      acc(0, EBSC_SZ_HALF, 'h101, 32'hAB44, 7, 5'h02, 2);
      acc(0, EBSC_SZ_HALF, 'h100, 32'hAB44, 9, 0, 5);
      acc(0, EBSC_SZ_WORD, 'h0, 0, 9, 5'h0C, 10);
      cmp32(beats, 4);
      wr(EBSC_OFS_BUSCTL, 16'h2000);
      acc(0, EBSC_SZ_WORD, 'h0, 0, 9, 5'h0C, 18);
      cmp32(beats, 8);
      wr(EBSC_OFS_BUSCTL, 16'h0001);
      slow <= 1'b1;
      acc(0, EBSC_SZ_HALF, 'h100, 32'hAB44, 9, 0, 0);
      cmp32({31'h0, len > 4}, 32'h1);
      acc(0, EBSC_SZ_HALF, 'h100, 32'hAB44, 9, 5'h08, 4);
      acc(1, EBSC_SZ_HALF, 'h100, 32'h5566, 9, 5'h08, 0);
      cmp32({31'h0, len > 5}, 32'h1);
      slow <= 1'b0;
      rst(1'b1);
      rd(EBSC_OFS_PAIR11, 16'h0030);
      rd(EBSC_OFS_BUSCTL, 16'h0001);
      print_verdict();
   end
endmodule : tb_ebsc_ctrl
